// file: hdl/cmb_buffer_manager.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cmb_buffer_manager (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       rx_byte_valid,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_frame_end,
    input  wire logic       rx_filter_hit,
    input  wire logic       sof_req,
    output logic            tx_valid,
    output logic [7:0]      tx_byte,
    output logic            tx_last,
    input  wire logic       tx_ready,
    output logic            tx_busy
);
    logic [7:0]                   mem_reg [0:cmb_pkg::MEM_BYTES-1];
    cmb_pkg::cmb_mode_t           mode_reg;
    logic [5:0]                   dir_reg;
    logic [4:0]                   fp_reg;
    logic [2:0]                   wr_ptr_reg;
    logic                         ovf_reg;
    logic [7:0]                   rdata_reg;
    cmb_pkg::cmb_tx_state_t       tx_state_reg;
    logic [2:0]                   tx_buf_reg;
    logic [3:0]                   tx_cnt_reg;
    logic [7:0]                   tx_byte_reg;
    logic                         mab_done;
    logic                         mab_accept;
    logic [cmb_pkg::MSG_BITS-1:0] mab_data;
    logic [3:0]                   fifo_len;
    logic [2:0]                   rx_tgt;
    logic                         rx_tgt_ok;
    logic                         copy;
    logic                         in_win;
    logic [2:0]                   acc_buf;
    logic                         acc_ok;
    logic [5:0]                   arb_req;
    logic [11:0]                  arb_prio;
    logic                         arb_valid;
    logic [2:0]                   arb_idx;
    logic                         tx_start;
    logic                         tx_clr;
    logic                         is_fifo;
    logic                         is_enh;

    function automatic int midx(input logic [2:0] b, input logic [3:0] y);
        return int'(b) * cmb_pkg::BUF_BYTES + int'(y);
    endfunction

    // buffer can take a received message in the current mode
    function automatic logic rx_capable(input logic [2:0] b, input logic enh, input logic [5:0] dir);
        if (b < 3'(cmb_pkg::NDED))
            return 1'b1;
        return enh && !dir[b - 3'(cmb_pkg::NDED)];
    endfunction

    // chain ends at the first programmable transmit buffer
    function automatic logic [3:0] chain_len(input logic [5:0] dir);
        logic [3:0] len;
        len = cmb_pkg::FIFO_MAX;
        for (int i = cmb_pkg::NPROG - 1; i >= 0; i--) begin
            if (dir[i])
                len = 4'(i + cmb_pkg::NDED);
        end
        return len;
    endfunction

    assign is_fifo  = mode_reg == cmb_pkg::CMB_ENH_FIFO;
    assign is_enh   = mode_reg != cmb_pkg::CMB_LEGACY;
    assign fifo_len = chain_len(dir_reg);

    cmb_msg_assembly u_mab (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .byte_valid   (rx_byte_valid),
        .byte_in      (rx_byte),
        .frame_end    (rx_frame_end),
        .frame_accept (rx_filter_hit),
        .msg_done     (mab_done),
        .msg_accept   (mab_accept),
        .msg_data     (mab_data)
    );

    // pick the receive target: chain slot in fifo mode, else lowest free buffer
    always_comb begin
        rx_tgt    = 3'h0;
        rx_tgt_ok = 1'b0;
        if (is_fifo) begin
            rx_tgt    = (4'(wr_ptr_reg) < fifo_len) ? wr_ptr_reg : 3'h0;
            rx_tgt_ok = !mem_reg[midx(rx_tgt, cmb_pkg::BYTE_CTL)][cmb_pkg::RX_FULL_BIT];
        end else begin
            for (int i = cmb_pkg::NBUF - 1; i >= 0; i--) begin
                if (rx_capable(3'(i), is_enh, dir_reg)
                    && !mem_reg[midx(3'(i), cmb_pkg::BYTE_CTL)][cmb_pkg::RX_FULL_BIT]) begin
                    rx_tgt    = 3'(i);
                    rx_tgt_ok = 1'b1;
                end
            end
        end
    end

    // unaccepted messages simply die in the assembly buffer
    assign copy = mab_done && mab_accept && rx_tgt_ok;

    // firmware view: receive buffers in fifo mode only through the pointer window
    always_comb begin
        in_win  = reg_addr[7:4] == cmb_pkg::ADDR_WIN_HI && reg_addr[3:0] <= cmb_pkg::BYTE_LAST
                  && is_fifo && 4'(fp_reg) < fifo_len;
        acc_buf = in_win ? fp_reg[2:0] : reg_addr[6:4];
        acc_ok  = in_win;
        if (!reg_addr[7] && reg_addr[3:0] <= cmb_pkg::BYTE_LAST) begin
            if (reg_addr[6:4] < 3'(cmb_pkg::NDED))
                acc_ok = !is_fifo;
            else
                acc_ok = is_enh && !(is_fifo && !dir_reg[reg_addr[6:4] - 3'(cmb_pkg::NDED)]);
        end
    end

    // transmit candidates: enhanced mode, transmit direction, request set
    always_comb begin
        for (int i = 0; i < cmb_pkg::NPROG; i++) begin
            arb_req[i]          = is_enh && dir_reg[i]
                                  && mem_reg[midx(3'(i + cmb_pkg::NDED), cmb_pkg::BYTE_CTL)][cmb_pkg::TX_REQ_BIT];
            arb_prio[2*i +: 2]  = mem_reg[midx(3'(i + cmb_pkg::NDED), cmb_pkg::BYTE_CTL)][cmb_pkg::TXP_LSB +: 2];
        end
    end

    cmb_tx_arbiter u_arb (
        .req       (arb_req),
        .prio      (arb_prio),
        .win_valid (arb_valid),
        .win_idx   (arb_idx)
    );

    assign tx_start = tx_state_reg == cmb_pkg::CMB_TX_IDLE && sof_req && arb_valid;
    assign tx_clr   = tx_state_reg == cmb_pkg::CMB_TX_SEND && tx_ready && tx_cnt_reg == cmb_pkg::BYTE_LAST;

    // buffer storage; the copy is last so a full flag set beats a firmware clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < cmb_pkg::MEM_BYTES; i++)
                mem_reg[i] <= 8'h00;
        end else begin
            if (tx_clr)
                mem_reg[midx(tx_buf_reg, cmb_pkg::BYTE_CTL)][cmb_pkg::TX_REQ_BIT] <= 1'b0;
            if (reg_wr && acc_ok)
                mem_reg[midx(acc_buf, reg_addr[3:0])] <= reg_wdata;
            if (copy) begin
                for (int j = 1; j <= cmb_pkg::MSG_BYTES; j++)
                    mem_reg[midx(rx_tgt, 4'(j))] <= mab_data[8*(j-1) +: 8];
                mem_reg[midx(rx_tgt, cmb_pkg::BYTE_CTL)][cmb_pkg::RX_FULL_BIT] <= 1'b1;
            end
        end
    end

    // mode, direction and pointer field; mode code 3 is refused
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_reg <= cmb_pkg::CMB_LEGACY;
            dir_reg  <= cmb_pkg::DIR_RST;
            fp_reg   <= cmb_pkg::FP_RST;
        end else if (reg_wr) begin
            if (reg_addr == cmb_pkg::ADDR_MODE && reg_wdata[1:0] != 2'h3)
                mode_reg <= cmb_pkg::cmb_mode_t'(reg_wdata[1:0]);
            if (reg_addr == cmb_pkg::ADDR_DIR)
                dir_reg <= reg_wdata[5:0];
            if (reg_addr == cmb_pkg::ADDR_CAN_CONTROL_REGISTER)
                fp_reg <= reg_wdata[4:0];
        end
    end

    // hardware fill pointer walks the chain; any write to the mode register restarts it
    always_ff @(posedge mclk) begin
        if (!rst_n)
            wr_ptr_reg <= 3'h0;
        else if (reg_wr && reg_addr == cmb_pkg::ADDR_MODE)
            wr_ptr_reg <= 3'h0;
        else if (copy && is_fifo)
            wr_ptr_reg <= (4'(rx_tgt) + 4'h1 >= fifo_len) ? 3'h0 : rx_tgt + 3'h1;
    end

    // overflow: accepted but nowhere to go; set wins over the write-0 clear
    always_ff @(posedge mclk) begin
        if (!rst_n)
            ovf_reg <= 1'b0;
        else if (mab_done && mab_accept && !rx_tgt_ok)
            ovf_reg <= 1'b1;
        else if (reg_wr && reg_addr == cmb_pkg::ADDR_STAT && !reg_wdata[cmb_pkg::OVF_BIT])
            ovf_reg <= 1'b0;
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (!rst_n || !reg_rd)
            rdata_reg <= 8'h00;
        else if (acc_ok)
            rdata_reg <= mem_reg[midx(acc_buf, reg_addr[3:0])];
        else begin
            unique case (reg_addr)
                cmb_pkg::ADDR_MODE:   rdata_reg <= {6'h00, mode_reg};
                cmb_pkg::ADDR_DIR:    rdata_reg <= {2'h0, dir_reg};
                cmb_pkg::ADDR_CAN_CONTROL_REGISTER: rdata_reg <= {wr_ptr_reg, fp_reg};
                cmb_pkg::ADDR_STAT:   rdata_reg <= {ovf_reg, 2'h0, tx_busy, fifo_len};
                default:              rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;

    // transmit sequencer: the choice is frozen at start of frame
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_state_reg <= cmb_pkg::CMB_TX_IDLE;
            tx_buf_reg   <= 3'h0;
            tx_cnt_reg   <= 4'h0;
        end else begin
            unique case (tx_state_reg)
                cmb_pkg::CMB_TX_IDLE: begin
                    if (tx_start) begin
                        tx_state_reg <= cmb_pkg::CMB_TX_SEND;
                        tx_buf_reg   <= arb_idx + 3'(cmb_pkg::NDED);
                        tx_cnt_reg   <= cmb_pkg::BYTE_FIRST;
                    end
                end
                cmb_pkg::CMB_TX_SEND: begin
                    if (tx_clr)
                        tx_state_reg <= cmb_pkg::CMB_TX_IDLE;
                    else if (tx_ready)
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                end
            endcase
        end
    end

    // outgoing byte is prefetched so the data output comes from a flop
    always_ff @(posedge mclk) begin
        if (!rst_n)
            tx_byte_reg <= 8'h00;
        else if (tx_start)
            tx_byte_reg <= mem_reg[midx(arb_idx + 3'(cmb_pkg::NDED), cmb_pkg::BYTE_FIRST)];
        else if (tx_state_reg == cmb_pkg::CMB_TX_SEND && tx_ready && !tx_clr)
            tx_byte_reg <= mem_reg[midx(tx_buf_reg, tx_cnt_reg + 4'h1)];
    end

    assign tx_valid = tx_state_reg == cmb_pkg::CMB_TX_SEND;
    assign tx_byte  = tx_byte_reg;
    assign tx_last  = tx_valid && tx_cnt_reg == cmb_pkg::BYTE_LAST;
    assign tx_busy  = tx_valid;

    // checks on the design's own behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_legacy_dedicated_only: assert property (copy && !is_enh |-> rx_tgt < 3'h2)
        else $error("legacy copy went past the dedicated buffers");
    a_gap_bytes_zero: assert property (reg_rd && !reg_addr[7] && reg_addr[3:0] > 4'hd |=> reg_rdata == 8'h00)
        else $error("byte beyond buffer end read nonzero");
    a_mab_full_flag: assert property (copy |=> mem_reg[midx($past(rx_tgt), 4'h0)][7])
        else $error("copied buffer not marked full");
    a_reject_no_copy: assert property (mab_done && !mab_accept |-> !copy ##1 !copy)
        else $error("rejected message was stored");
    a_legacy_prog_hidden: assert property (reg_rd && !is_enh && !reg_addr[7] && reg_addr[6:4] >= 3'h2
                                           |=> reg_rdata == 8'h00)
        else $error("programmable buffer visible in legacy mode");
    a_rx_dir_ignored: assert property (tx_start |-> dir_reg[arb_idx] ##1 tx_busy)
        else $error("receive buffer chosen for transmit");
    a_dir_after_reset: assert property ($rose(rst_n) |-> dir_reg == 6'h00)
        else $error("direction not receive after reset");
    a_fifo_in_chain: assert property (copy && is_fifo |-> 4'(rx_tgt) < fifo_len)
        else $error("fifo copy outside chain");
    a_fifo_len_range: assert property (fifo_len >= 4'h2 && fifo_len <= 4'h8 && (dir_reg != 6'h00 || fifo_len == 4'h8))
        else $error("fifo length out of range");
    a_tx_when_queued: assert property (tx_state_reg == cmb_pkg::CMB_TX_IDLE && sof_req && arb_req != 6'h00
                                       |=> tx_busy)
        else $error("queued buffer not started at start of frame");
    a_tx_highest: assert property (arb_valid |-> (arb_prio >> (2*arb_idx)) % 4 >= 0
                                   && !(arb_req[5] && arb_prio[11:10] > arb_prio[2*arb_idx +: 2])
                                   && !(arb_req[0] && arb_prio[1:0] > arb_prio[2*arb_idx +: 2]))
        else $error("lower priority buffer won");
    a_tx_tie_high: assert property (arb_valid && arb_req[5] && arb_prio[11:10] == arb_prio[2*arb_idx +: 2]
                                    |-> arb_idx == 3'h5)
        else $error("tie not given to higher buffer");
    a_tx_frame_len: assert property (tx_start |=> tx_valid [*8])
        else $error("transmit frame ended early");

    c_fifo_copy: cover property (copy && is_fifo);
    c_tx_tie: cover property (tx_start && arb_req[5] && arb_req[4] && arb_prio[11:10] == arb_prio[9:8]);
    c_overflow: cover property (mab_done && mab_accept && !rx_tgt_ok);
    c_tx_done: cover property (tx_clr);
endmodule // cmb_buffer_manager

// file: hdl/cmb_pkg.sv
package cmb_pkg;
    localparam int         NBUF        = 8;
    localparam int         NDED        = 2;
    localparam int         NPROG       = 6;
    localparam int         BUF_BYTES   = 14;
    localparam int         MEM_BYTES   = NBUF * BUF_BYTES;
    localparam int         MSG_BYTES   = 13;
    localparam int         MSG_BITS    = MSG_BYTES * 8;
    localparam logic [3:0] BYTE_CTL    = 4'h0;
    localparam logic [3:0] BYTE_FIRST  = 4'h1;
    localparam logic [3:0] BYTE_LAST   = 4'hd;
    localparam int         RX_FULL_BIT = 7;
    localparam int         TX_REQ_BIT  = 3;
    localparam int         TXP_LSB     = 0;
    localparam int         OVF_BIT     = 7;
    localparam int         BUSY_BIT    = 4;
    localparam logic [7:0] ADDR_MODE   = 8'h80;
    localparam logic [7:0] ADDR_DIR    = 8'h81;
    localparam logic [7:0] ADDR_CAN_CONTROL_REGISTER = 8'h82;
    localparam logic [7:0] ADDR_STAT   = 8'h83;
    localparam logic [3:0] ADDR_WIN_HI = 4'h9;
    localparam logic [5:0] DIR_RST     = 6'h00;
    localparam logic [4:0] FP_RST      = 5'h00;
    localparam logic [3:0] FIFO_MAX    = 4'h8;
    typedef enum logic [1:0] {CMB_LEGACY, CMB_ENH_LEGACY, CMB_ENH_FIFO} cmb_mode_t;
    typedef enum logic {CMB_TX_IDLE, CMB_TX_SEND} cmb_tx_state_t;
endpackage

// file: hdl/cmb_tx_arbiter.sv
`timescale 1ns/1ps
module cmb_tx_arbiter (
    input  wire logic [cmb_pkg::NPROG-1:0]   req,
    input  wire logic [2*cmb_pkg::NPROG-1:0] prio,
    output logic                             win_valid,
    output logic [2:0]                       win_idx
);
    logic [1:0] best;

    // ascending scan with >= hands ties to the higher buffer number
    always_comb begin
        win_valid = 1'b0;
        win_idx   = 3'h0;
        best      = 2'h0;
        for (int i = 0; i < cmb_pkg::NPROG; i++) begin
            if (req[i] && (!win_valid || prio[2*i +: 2] >= best)) begin
                win_valid = 1'b1;
                win_idx   = 3'(i);
                best      = prio[2*i +: 2];
            end
        end
    end
endmodule // cmb_tx_arbiter

// file: hdl/cmb_msg_assembly.sv
`timescale 1ns/1ps
module cmb_msg_assembly (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         byte_valid,
    input  wire logic [7:0]                   byte_in,
    input  wire logic                         frame_end,
    input  wire logic                         frame_accept,
    output logic                              msg_done,
    output logic                              msg_accept,
    output logic [cmb_pkg::MSG_BITS-1:0]      msg_data
);
    logic [cmb_pkg::MSG_BITS-1:0] asm_reg;
    logic [3:0]                   cnt_reg;

    // collect one frame; bytes past the thirteenth are dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            asm_reg <= '0;
            cnt_reg <= 4'h0;
        end else if (frame_end) begin
            asm_reg <= '0;
            cnt_reg <= 4'h0;
        end else if (byte_valid && cnt_reg < cmb_pkg::BYTE_LAST) begin
            asm_reg[8*cnt_reg +: 8] <= byte_in;
            cnt_reg                 <= cnt_reg + 4'h1;
        end
    end

    // hand the whole message over in one pulse, then start afresh
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            msg_done   <= 1'b0;
            msg_accept <= 1'b0;
            msg_data   <= '0;
        end else begin
            msg_done   <= frame_end;
            msg_accept <= frame_end && frame_accept;
            if (frame_end)
                msg_data <= asm_reg;
        end
    end
endmodule // cmb_msg_assembly

// file: tb/cmb_can_node_model.sv
`timescale 1ns/1ps
// far-side can nodes: frame source on the receive side, byte sink on the transmit side
module cmb_can_node_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       slow,
    output logic            rx_byte_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_frame_end,
    output logic            rx_filter_hit,
    output logic            sof_req,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] cap [0:12];
    int         cnt;
    int         frames;
    int         last_len;

    // quiet bus at time zero
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte       = 8'h00;
        rx_frame_end  = 1'b0;
        rx_filter_hit = 1'b0;
        sof_req       = 1'b0;
        tx_ready      = 1'b0;
    end

    // one frame of 13 bytes, then the end pulse with the filter verdict
    task automatic send_frame(input logic [7:0] base, input logic hit);
        for (int i = 0; i < 13; i++) begin
            @(posedge mclk);
            rx_byte_valid <= 1'b1;
            rx_byte       <= base + 8'(i);
        end
        @(posedge mclk);
        rx_byte_valid <= 1'b0;
        rx_byte       <= ~(base + 8'h0c); // idle lines flip so stale bytes never pass
        rx_frame_end  <= 1'b1;
        rx_filter_hit <= hit;
        @(posedge mclk);
        rx_frame_end  <= 1'b0;
        rx_filter_hit <= ~hit;
        repeat (2) @(posedge mclk);
    endtask

    // start of frame request from the protocol engine
    task automatic start_frame();
        @(posedge mclk);
        sof_req <= 1'b1;
        @(posedge mclk);
        sof_req <= 1'b0;
    endtask

    // slow sink stalls every other cycle to stretch the frame
    always @(posedge mclk) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end

    // capture offered bytes at accepting edges
    always @(posedge mclk) begin
        if (!rst_n) begin
            cnt    <= 0;
            frames <= 0;
        end else if (tx_valid && tx_ready) begin
            if (cnt < 13) begin
                cap[cnt] <= tx_byte;
            end
            if (tx_last) begin
                cnt      <= 0;
                frames   <= frames + 1;
                last_len <= cnt + 1;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // cmb_can_node_model

// file: tb/cmb_buffer_manager_test.sv
`timescale 1ns/1ps
module cmb_buffer_manager_test;
    logic       mclk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       rx_byte_valid;
    logic [7:0] rx_byte;
    logic       rx_frame_end;
    logic       rx_filter_hit;
    logic       sof_req;
    logic       tx_valid;
    logic [7:0] tx_byte;
    logic       tx_last;
    logic       tx_ready;
    logic       tx_busy;
    logic       slow;
    logic [7:0] d;
    int         bad_count;
    int         n_compared;

    cmb_buffer_manager i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_filter_hit(rx_filter_hit), .sof_req(sof_req),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready), .tx_busy(tx_busy));
    cmb_can_node_model i_node (.mclk(mclk), .rst_n(rst_n), .slow(slow), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_filter_hit(rx_filter_hit), .sof_req(sof_req),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));

    // 250 mhz
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // one-cycle strobes; read data stands only in the cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // bounded wait for the sink to count n whole frames
    task automatic wait_frames(input int n);
        for (int i = 0; i < 400 && i_node.frames < n; i++) @(posedge mclk);
        if (i_node.frames < n) begin
            $display("Error tx frames expected %0d seen %0d", n, i_node.frames);
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic t_reset_values();
        rd(8'h80, d); chk("mode", 8'h00, d & 8'h03);
        rd(8'h81, d); chk("direction", 8'h00, d);
        rd(8'h83, d); chk("status", 8'h08, d);
        wr(8'h80, 8'h03); // refused mode code
        rd(8'h80, d); chk("mode 3 refused", 8'h00, d & 8'h03);
    endtask

    task automatic t_legacy_rx();
        i_node.send_frame(8'h10, 1'b1);
        rd(8'h01, d); chk("rx0 byte1", 8'h10, d);
        rd(8'h0d, d); chk("rx0 byte13", 8'h1c, d);
        rd(8'h00, d); chk("rx0 full", 8'h80, d & 8'h80);
        rd(8'h0e, d); chk("gap byte", 8'h00, d);
        i_node.send_frame(8'h20, 1'b0);
        rd(8'h10, d); chk("rx1 after miss", 8'h00, d & 8'h80);
        i_node.send_frame(8'h20, 1'b1);
        rd(8'h11, d); chk("rx1 byte1", 8'h20, d);
        rd(8'h21, d); chk("prog hidden", 8'h00, d);
        i_node.send_frame(8'h50, 1'b1);
        rd(8'h83, d); chk("overflow", 8'h80, d & 8'h80);
        wr(8'h83, 8'h00);
        rd(8'h83, d); chk("overflow clear", 8'h00, d & 8'h80);
    endtask

    task automatic t_enh_legacy_rx();
        wr(8'h80, 8'h01);
        i_node.send_frame(8'h30, 1'b1);
        rd(8'h21, d); chk("prog rx byte1", 8'h30, d);
        rd(8'h20, d); chk("prog rx full", 8'h80, d & 8'h80);
    endtask

    task automatic t_tx_priority();
        logic [2:0] ord [4];
        ord = '{3'd7, 3'd4, 3'd5, 3'd6};
        wr(8'h81, 8'h3c);
        for (int b = 4; b < 8; b++) begin
            wr(8'(b * 16 + 1), 8'(b * 16));
            wr(8'(b * 16 + 13), 8'(8'ha0 + b));
        end
        // tie between 4 and 7 at top level, 5 mid, 6 lowest
        wr(8'h40, 8'h0b); wr(8'h50, 8'h09); wr(8'h60, 8'h08); wr(8'h70, 8'h0b);
        for (int k = 0; k < 4; k++) begin
            slow <= (k != 0);
            i_node.start_frame();
            #1 chk("tx busy", 8'h01, {7'h00, tx_busy});
            rd(8'h83, d); chk("status busy", 8'h10, d & 8'h10);
            wait_frames(k + 1);
            chk("tx first", 8'(ord[k] * 16), i_node.cap[0]);
            chk("tx last", 8'(8'ha0 + ord[k]), i_node.cap[12]);
            chk("tx length", 8'h0d, 8'(i_node.last_len));
        end
        rd(8'h70, d); chk("tx request", 8'h00, d & 8'h08);
        i_node.start_frame();
        #1 chk("idle sof", 8'h00, {7'h00, tx_busy});
    endtask

    task automatic t_legacy_no_tx();
        // queue a request while enhanced, then drop to legacy: it must stay unsent
        wr(8'h40, 8'h0b);
        wr(8'h80, 8'h00);
        i_node.start_frame();
        #1 chk("legacy sof", 8'h00, {7'h00, tx_busy});
    endtask

    task automatic t_fifo();
        wr(8'h80, 8'h01);
        for (int b = 0; b < 4; b++) wr(8'(b * 16), 8'h00);
        wr(8'h81, 8'h04);
        wr(8'h80, 8'h02);
        rd(8'h83, d); chk("fifo length", 8'h04, d & 8'h0f);
        i_node.send_frame(8'h40, 1'b1);
        i_node.send_frame(8'h60, 1'b1);
        // firmware keeps the read order itself
        rd(8'h91, d); chk("fifo slot0", 8'h40, d);
        wr(8'h82, 8'h01);
        rd(8'h91, d); chk("fifo slot1", 8'h60, d);
        rd(8'h90, d); chk("fifo slot1 full", 8'h80, d & 8'h80);
        rd(8'h11, d); chk("direct rx1", 8'h00, d);
        wr(8'h82, 8'h04);
        rd(8'h91, d); chk("pointer past end", 8'h00, d);
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        $display("Error run expected end seen timeout");
        bad_count++;
        wrap_up();
    end

    initial begin
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        slow      = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_values();
        t_legacy_rx();
        t_enh_legacy_rx();
        t_tx_priority();
        t_legacy_no_tx();
        t_fifo();
        wrap_up();
    end
endmodule // cmb_buffer_manager_test
